// ===== pkg/sub_dp_regs.svh
// field positions, opcodes and address limits of the subtract datapath
`ifndef SUB_DP_REGS_SVH
`define SUB_DP_REGS_SVH
`define OPC6_HI        15
`define OPC6_LO        10
`define OPC8_LO        8
`define DEST_BIT       9
`define ACCESS_BIT     8
`define FADDR_HI       7
`define OPC_SUB_FILE   6'h17
`define OPC_SUB_BORROW 6'h16
`define OPC_SUB_LIT    8'h08
`define LOW_LIMIT      8'h5f
`define ACCESS_LOW_BNK 6'h00
`define NIB_HI         3
`endif

// ===== pkg/sub_dp_pkg.sv
// types shared by the subtract datapath modules
package sub_dp_pkg;
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1   = 3'b001,
    ST_Q2   = 3'b010,
    ST_Q3   = 3'b011,
    ST_Q4   = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_FILE   = 2'b01,
    OP_BORROW = 2'b10,
    OP_LIT    = 2'b11
  } sub_op_t;
endpackage : sub_dp_pkg

// ===== core/sub_alu.sv
// eight-bit subtractor with borrow input and flag generation
`include "sub_dp_regs.svh"
module sub_alu (
  input  wire logic                   borrow_in,
  input  wire logic [7:0]             minuend_in,
  input  wire logic [7:0]             subtrahend_in,
  output logic      [7:0]             result_out,
  output sub_dp_pkg::alu_flags_t      flags_out
);
  import sub_dp_pkg::*;

  logic [8:0] full_diff;
  logic [4:0] nib_diff;

  always_comb begin
    full_diff  = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {8'h00, borrow_in};
    nib_diff   = {1'b0, minuend_in[`NIB_HI:0]} - {1'b0, subtrahend_in[`NIB_HI:0]}
                 - {4'h0, borrow_in};
    result_out = full_diff[7:0];
    // wrap modulo 256; carry means no borrow out of bit 7 [RULE10]
    flags_out.c  = ~full_diff[8];                                  // [RULE8]
    flags_out.dc = ~nib_diff[4];                                   // [RULE11]
    flags_out.z  = (full_diff[7:0] == 8'h00);                      // [RULE9]
    flags_out.n  = full_diff[7];                                   // [RULE9]
    flags_out.ov = (minuend_in[7] != subtrahend_in[7]) &&
                   (full_diff[7] != minuend_in[7]);                // [RULE11]
  end
endmodule : sub_alu

// ===== core/subtract_instruction_datapath.sv
// four-phase execution datapath for the subtract instructions
// ---------------------------------------------------------------
// Overview of operation
// RULE1 - file-minus-accumulator opcode, decoded from top bits
// RULE2 - borrow variant also subtracts inverted carry
// RULE3 - dest bit: 0 accumulator, 1 file register
// RULE4 - access bit: 0 shared bank, 1 bank pointer
// RULE5 - extended set, low address: indexed literal offset
// RULE6 - only n, ov, c, dc, z updated
// RULE7 - one cycle: decode, read, compute, write
// RULE8 - carry set when no borrow occurred
// RULE9 - zero on all-zero result, negative copies msb
// RULE10 - literal subtract wraps, carry cleared on underflow
// RULE11 - nibble carry and signed overflow flags
// ---------------------------------------------------------------
`include "sub_dp_regs.svh"
module subtract_instruction_datapath #(
  parameter int BANK_W    = 6,
  parameter int ADDR_W    = 14,
  parameter logic [5:0] ACCESS_HIGH_BNK = 6'h3f
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   start_in,
  input  wire logic [15:0]            instr_in,
  input  wire logic [7:0]             acc_in,
  input  wire logic                   carry_in,
  input  wire logic [BANK_W-1:0]      bank_pointer_in,
  input  wire logic                   ext_set_en_in,
  input  wire logic [ADDR_W-1:0]      index_base_in,
  input  wire logic [7:0]             file_rd_data_in,
  output logic                        ready_out,
  output logic                        file_rd_en_out,
  output logic [ADDR_W-1:0]           file_addr_out,
  output logic                        file_wr_en_out,
  output logic                        acc_wr_en_out,
  output logic [7:0]                  result_out,
  output logic                        status_wr_en_out,
  output sub_dp_pkg::alu_flags_t      status_out,
  output logic                        done_out,
  output logic                        illegal_out
);
  import sub_dp_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (BANK_W < 1 || BANK_W > 6 || ADDR_W != BANK_W + 8) begin : g_chk
    $error("address widths unsupported");
  end

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic sub_op_t decode_op(input logic [15:0] w);
    if (w[`OPC6_HI:`OPC6_LO] == `OPC_SUB_FILE)
      return OP_FILE;                                              // [RULE1]
    if (w[`OPC6_HI:`OPC6_LO] == `OPC_SUB_BORROW)
      return OP_BORROW;                                            // [RULE2]
    if (w[`OPC6_HI:`OPC8_LO] == `OPC_SUB_LIT)
      return OP_LIT;
    return OP_NONE;
  endfunction : decode_op

  function automatic logic [ADDR_W-1:0] file_addr(
    input logic [15:0] w, input logic [BANK_W-1:0] bnk,
    input logic ext, input logic [ADDR_W-1:0] base);
    logic [7:0] f;
    f = w[`FADDR_HI:0];
    if (w[`ACCESS_BIT])
      return {bnk, f};                                             // [RULE4]
    if (ext && f <= `LOW_LIMIT)
      return ADDR_W'(base + {{(ADDR_W-8){1'b0}}, f});              // [RULE5]
    if (f <= `LOW_LIMIT)
      return {BANK_W'(`ACCESS_LOW_BNK), f};                        // [RULE4]
    return {ACCESS_HIGH_BNK[BANK_W-1:0], f};
  endfunction : file_addr

  // ---------------------------------------------------------------
  // latched instruction context
  // ---------------------------------------------------------------
  phase_t                state_r;
  logic [15:0]           instr_r;
  logic [7:0]            acc_r;
  logic                  carry_r;
  logic [BANK_W-1:0]     bank_r;
  logic                  ext_r;
  logic [ADDR_W-1:0]     base_r;
  logic [7:0]            operand_r;
  sub_op_t               op_w;
  logic                  take_w;
  logic [7:0]            alu_res_w;
  alu_flags_t            alu_flags_w;
  logic                  borrow_w;
  logic [7:0]            minu_w;
  logic [7:0]            subt_w;

  assign take_w   = start_in && (state_r == ST_IDLE);
  assign op_w     = decode_op(instr_r);
  // cleared carry acts as a borrow of one
  assign borrow_w = (op_w == OP_BORROW) ? ~carry_r : 1'b0;         // [RULE2]
  assign minu_w   = (op_w == OP_LIT) ? instr_r[`FADDR_HI:0] : operand_r;
  assign subt_w   = acc_r;                                         // [RULE1]

  sub_alu u_alu (
    .borrow_in     (borrow_w),
    .minuend_in    (minu_w),
    .subtrahend_in (subt_w),
    .result_out    (alu_res_w),
    .flags_out     (alu_flags_w)
  );

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)                                        // [RULE7]
        ST_IDLE: if (take_w) state_r <= ST_Q1;
        ST_Q1:   state_r <= ST_Q2;
        ST_Q2:   state_r <= ST_Q3;
        ST_Q3:   state_r <= ST_Q4;
        ST_Q4:   state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      instr_r <= 16'h0000;
      acc_r   <= 8'h00;
      carry_r <= 1'b0;
      bank_r  <= '0;
      ext_r   <= 1'b0;
      base_r  <= '0;
    end else if (take_w) begin
      instr_r <= instr_in;
      acc_r   <= acc_in;
      carry_r <= carry_in;
      bank_r  <= bank_pointer_in;
      ext_r   <= ext_set_en_in;
      base_r  <= index_base_in;
    end
  end

  // ---------------------------------------------------------------
  // file read: address set at end of decode, data caught in q2
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      file_rd_en_out <= 1'b0;
      file_addr_out  <= '0;
      operand_r      <= 8'h00;
    end else begin
      file_rd_en_out <= 1'b0;
      if (state_r == ST_Q1 && (op_w == OP_FILE || op_w == OP_BORROW)) begin
        file_rd_en_out <= 1'b1;                                    // [RULE7]
        file_addr_out  <= file_addr(instr_r, bank_r, ext_r, base_r);
      end
      if (state_r == ST_Q2)
        operand_r <= file_rd_data_in;
    end
  end

  // ---------------------------------------------------------------
  // q4 write-back; strobes held one cycle only, result and status kept
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      file_wr_en_out   <= 1'b0;
      acc_wr_en_out    <= 1'b0;
      status_wr_en_out <= 1'b0;
      result_out       <= 8'h00;
      status_out       <= '0;
      done_out         <= 1'b0;
      illegal_out      <= 1'b0;
    end else begin
      file_wr_en_out   <= 1'b0;
      acc_wr_en_out    <= 1'b0;
      status_wr_en_out <= 1'b0;
      done_out         <= 1'b0;
      illegal_out      <= 1'b0;
      if (state_r == ST_Q3) begin
        done_out <= 1'b1;
        if (op_w == OP_NONE) begin
          // unknown word: no write, so state stays untouched
          illegal_out <= 1'b1;
        end else begin
          result_out       <= alu_res_w;
          status_out       <= alu_flags_w;                         // [RULE6]
          status_wr_en_out <= 1'b1;                                // [RULE6]
          if (op_w != OP_LIT && instr_r[`DEST_BIT])
            file_wr_en_out <= 1'b1;                                // [RULE3]
          else
            acc_wr_en_out  <= 1'b1;                                // [RULE3]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // ready back only once the write phase is over
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      ready_out <= 1'b1;
    else if (take_w)
      ready_out <= 1'b0;
    else if (state_r == ST_Q4)
      ready_out <= 1'b1;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_read_phase;
    !file_rd_en_out ##1 (file_rd_en_out || op_w == OP_LIT || op_w == OP_NONE) ##1 !file_rd_en_out;
  endsequence
  sequence s_write_phase;
    !done_out ##1 done_out ##1 !done_out && ready_out;
  endsequence

  property p_four_phases;
    take_w |-> ##1 s_read_phase ##0 s_write_phase;
  endproperty
  a_four_phases: assert property (p_four_phases) else $error("phase timing wrong"); // [RULE7]

  property p_sub_file;
    file_wr_en_out && op_w == OP_FILE |-> result_out == 8'(operand_r - acc_r);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("file subtract wrong"); // [RULE1]

  property p_sub_borrow;
    done_out && op_w == OP_BORROW && !illegal_out |->
      result_out == 8'(operand_r - acc_r - {7'h00, ~carry_r});
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong"); // [RULE2]

  property p_dest;
    done_out && op_w != OP_NONE |->
      (file_wr_en_out == (instr_r[`DEST_BIT] && op_w != OP_LIT)) &&
      (acc_wr_en_out != file_wr_en_out);
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong"); // [RULE3]

  property p_banked;
    take_w && instr_in[`ACCESS_BIT] && decode_op(instr_in) == OP_FILE |->
      ##2 file_addr_out == {$past(bank_pointer_in, 2), $past(instr_in[`FADDR_HI:0], 2)};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong"); // [RULE4]

  property p_indexed;
    file_rd_en_out && !instr_r[`ACCESS_BIT] && ext_r &&
      instr_r[`FADDR_HI:0] <= `LOW_LIMIT |->
      file_addr_out == ADDR_W'(base_r + {{(ADDR_W-8){1'b0}}, instr_r[`FADDR_HI:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // [RULE5]

  property p_status_only_valid;
    status_wr_en_out |-> done_out && !illegal_out;
  endproperty
  a_status_only_valid: assert property (p_status_only_valid) else $error("bad flag write"); // [RULE6]

  property p_carry;
    status_wr_en_out |->
      status_out.c == ({1'b0, minu_w} >= {1'b0, acc_r} + {8'h00, borrow_w});
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong"); // [RULE8]

  property p_zero_neg;
    status_wr_en_out |-> status_out.z == (result_out == 8'h00) && status_out.n == result_out[7];
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("zero or negative wrong"); // [RULE9]

  property p_lit_wrap;
    acc_wr_en_out && op_w == OP_LIT && instr_r[`FADDR_HI:0] < acc_r |->
      !status_out.c && result_out == 8'(instr_r[`FADDR_HI:0] - acc_r);
  endproperty
  a_lit_wrap: assert property (p_lit_wrap) else $error("literal wrap wrong"); // [RULE10]

  property p_ov_dc;
    status_wr_en_out |->
      status_out.ov == ((minu_w[7] != acc_r[7]) && (result_out[7] != minu_w[7])) &&
      status_out.dc == ({1'b0, minu_w[3:0]} >= {1'b0, acc_r[3:0]} + {4'h0, borrow_w});
  endproperty
  a_ov_dc: assert property (p_ov_dc) else $error("ov or dc wrong"); // [RULE11]
endmodule : subtract_instruction_datapath

// ===== tb/tb_subtract_instruction_datapath.sv
// self-checking bench for the subtract instruction datapath
module tb_subtract_instruction_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  import sub_dp_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0]  acc;
    logic        c;
    logic [5:0]  bnk;
    logic        ext;
    logic [13:0] base;
    logic [7:0]  fd;
  } row_t;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        start_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [7:0]  acc_in = 8'h00;
  logic        carry_in = 1'b0;
  logic [5:0]  bank_pointer_in = 6'h00;
  logic        ext_set_en_in = 1'b0;
  logic [13:0] index_base_in = 14'h0000;
  logic [7:0]  mem_val = 8'h00;
  wire logic [7:0] file_rd_data_in;
  logic        ready_out, file_rd_en_out, file_wr_en_out, acc_wr_en_out;
  logic        status_wr_en_out, done_out, illegal_out;
  logic [13:0] file_addr_out;
  logic [7:0]  result_out;
  alu_flags_t  status_out;
  int          fail_count = 0;
  int          tests_run = 0;
  int          k, dones;
  // read port is combinational; outside the strobe it shows junk, not the last value
  assign file_rd_data_in = file_rd_en_out ? mem_val : ~mem_val;
  always #10 ref_clk_in = ~ref_clk_in;
  subtract_instruction_datapath i_dut (
    .ref_clk_in       (ref_clk_in),
    .resetn_in        (resetn_in),
    .start_in         (start_in),
    .instr_in         (instr_in),
    .acc_in           (acc_in),
    .carry_in         (carry_in),
    .bank_pointer_in  (bank_pointer_in),
    .ext_set_en_in    (ext_set_en_in),
    .index_base_in    (index_base_in),
    .file_rd_data_in  (file_rd_data_in),
    .ready_out        (ready_out),
    .file_rd_en_out   (file_rd_en_out),
    .file_addr_out    (file_addr_out),
    .file_wr_en_out   (file_wr_en_out),
    .acc_wr_en_out    (acc_wr_en_out),
    .result_out       (result_out),
    .status_wr_en_out (status_wr_en_out),
    .status_out       (status_out),
    .done_out         (done_out),
    .illegal_out      (illegal_out)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check_val
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [13:0] exp_addr(input row_t r);
    if (r.ins[8]) return {r.bnk, r.ins[7:0]};
    if (r.ext && r.ins[7:0] <= 8'h5f) return r.base + {6'h00, r.ins[7:0]};
    if (r.ins[7:0] <= 8'h5f) return {6'h00, r.ins[7:0]};
    return {6'h3f, r.ins[7:0]};
  endfunction : exp_addr
  task automatic drive(input row_t r, input logic st);
    start_in        <= st;
    instr_in        <= r.ins;
    acc_in          <= r.acc;
    carry_in        <= r.c;
    bank_pointer_in <= r.bnk;
    ext_set_en_in   <= r.ext;
    index_base_in   <= r.base;
    mem_val         <= r.fd;
  endtask : drive
  task automatic run_op(input row_t r);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] m, res;
    logic       b, fop, lit, ill, rd2;
    int         n;
    fop = (r.ins[15:10] == 6'h17) || (r.ins[15:10] == 6'h16);
    lit = r.ins[15:8] == 8'h08;
    ill = !fop && !lit;
    m = lit ? r.ins[7:0] : r.fd;
    b = (r.ins[15:10] == 6'h16) ? ~r.c : 1'b0;
    full = {1'b0, m} - {1'b0, r.acc} - {8'h00, b};
    low = {1'b0, m[3:0]} - {1'b0, r.acc[3:0]} - {4'h0, b};
    res = full[7:0];
    n = 0;
    rd2 = 1'b0;
    @(posedge ref_clk_in);
    drive(r, 1'b1);
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    while (done_out !== 1'b1 && n < 8) begin
      @(negedge ref_clk_in);
      n++;
      if (n == 2) rd2 = file_rd_en_out;
    end
    check_val(16'(n), 16'h0004);
    check_val(16'(rd2), 16'(fop));
    if (fop) check_val(16'(file_addr_out), 16'(exp_addr(r)));
    check_val(16'(illegal_out), 16'(ill));
    check_val(16'(file_wr_en_out), 16'(fop && r.ins[9]));
    check_val(16'(acc_wr_en_out), 16'(lit || (fop && !r.ins[9])));
    check_val(16'(status_wr_en_out), 16'(!ill));
    if (!ill) begin
      check_val(16'(result_out), 16'(res));
      check_val(16'(status_out), 16'({res[7], (m[7] != r.acc[7]) && (res[7] != m[7]),
                res == 8'h00, ~low[4], ~full[8]}));
    end
    @(negedge ref_clk_in);
    check_val(16'({done_out, file_wr_en_out, acc_wr_en_out}), 16'h0000);
  endtask : run_op
  // ------------------------------------------------------------
  // ordinary cases: instr, acc, carry, bank, ext, base, file data
  // ------------------------------------------------------------
  row_t rows[17] = '{
    '{16'h5e10, 8'h02, 1'b0, 6'h00, 1'b0, 14'h0000, 8'h03},
    '{16'h5c10, 8'h02, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h02},
    '{16'h5e10, 8'h02, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h01},
    '{16'h5a10, 8'h0d, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h19},
    '{16'h5810, 8'h1a, 1'b0, 6'h00, 1'b0, 14'h0000, 8'h1b},
    '{16'h5a10, 8'h0e, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h03},
    '{16'h0802, 8'h01, 1'b0, 6'h00, 1'b0, 14'h0000, 8'haa},
    '{16'h0802, 8'h02, 1'b1, 6'h00, 1'b0, 14'h0000, 8'haa},
    '{16'h0802, 8'h03, 1'b1, 6'h00, 1'b0, 14'h0000, 8'haa},
    '{16'h5d23, 8'h33, 1'b0, 6'h05, 1'b1, 14'h0100, 8'h40},
    '{16'h5c20, 8'h01, 1'b1, 6'h00, 1'b1, 14'h0100, 8'h11},
    '{16'h5ca0, 8'h01, 1'b1, 6'h00, 1'b1, 14'h0100, 8'h80},
    '{16'h5e5f, 8'h01, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h10},
    '{16'h5a60, 8'hff, 1'b0, 6'h00, 1'b0, 14'h0000, 8'h7f},
    '{16'h5e5f, 8'h81, 1'b1, 6'h2a, 1'b1, 14'h3fff, 8'h7f},
    '{16'h0900, 8'h01, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h05},
    '{16'h5400, 8'h01, 1'b1, 6'h00, 1'b0, 14'h0000, 8'h05}
  };
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    check_val(16'({ready_out, done_out, status_wr_en_out, file_rd_en_out}), 16'h0008);
    resetn_in <= 1'b1;
    foreach (rows[i]) run_op(rows[i]);
    // held start: taken again only once ready returns, never while busy
    @(posedge ref_clk_in);
    drive(rows[0], 1'b1);
    dones = 0;
    // stop before ready returns a second time, so no third word slips in
    for (k = 0; k <= 9; k++) begin
      @(negedge ref_clk_in);
      if (done_out === 1'b1) dones++;
      if (k == 3) check_val(16'(ready_out), 16'h0000);
    end
    check_val(16'(dones), 16'h0002);
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    // reset in mid-instruction clears the pipe; no late write may escape
    drive(rows[1], 1'b1);
    repeat (3) @(posedge ref_clk_in);
    start_in  <= 1'b0;
    resetn_in <= 1'b0;
    @(negedge ref_clk_in);
    check_val(16'({ready_out, done_out, acc_wr_en_out, file_rd_en_out}), 16'h0008);
    @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    run_op(rows[3]);
    end_of_test();
  end
endmodule : tb_subtract_instruction_datapath
